// File: crc_check_cfg.svh
// Offsets, field positions, reset values and timing counts of the configuration checker.
`ifndef CRC_CHECK_CFG_SVH
`define CRC_CHECK_CFG_SVH
`define CLK_PERIOD_NS 40
`define REPORT_UPDATE_CYCLES 32
`define FLAG_LOW_CYCLES 32
`define FRAME_WORDS 16
`define FRAME_COUNT 8
`define FI_WIDTH 46
`define FI_BYTE_VAL_MSB 31
`define FI_BYTE_VAL_LSB 0
`define FI_LOC_MSB 41
`define FI_LOC_LSB 32
`define FI_TYPE_MSB 45
`define FI_TYPE_LSB 42
`define FAULT_INJECT_CODE 10'h015
`define REPORT_SHIFT_CODE 10'h017
`define REPORT_WIDTH 67
`define REPORT_TYPE_MSB 66
`define REPORT_TYPE_LSB 63
`define REPORT_SYN_MSB 31
`define REPORT_SYN_LSB 0
`define REPORT_LOC_MSB 62
`define REPORT_LOC_LSB 32
`define ERR_NONE 4'h0
`define ERR_SINGLE 4'h1
`define ERR_DOUBLE 4'h2
`define ERR_OTHER 4'hf
`define CRC_POLY 32'h04c11db7
`define CRC_INIT 32'hffffffff
`endif

// File: crc_check_pkg.sv
// Types shared by the configuration checker files.
package crc_check_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CALC,
    ST_UPDATE,
    ST_FLAG,
    ST_LOW
  } check_state_t;
  typedef logic [31:0] word_t;
  typedef logic [66:0] report_t;
endpackage

// File: frame_mem.sv
// Small configuration frame memory with registered read data.
`include "crc_check_cfg.svh"
module frame_mem (
  input wire logic core_clk_in,
  input wire logic [6:0] rd_addr_in,
  input wire logic wr_en_in,
  input wire logic [6:0] wr_addr_in,
  input wire crc_check_pkg::word_t wr_data_in,
  output crc_check_pkg::word_t rd_data_out
);
  import crc_check_pkg::*;
  word_t mem_reg [0:127];
  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_reg[rd_addr_in];
  end
endmodule

// File: config_crc_checker.sv
// Configuration memory CRC checker with error report and test-port fault injection.
`include "crc_check_cfg.svh"
module config_crc_checker (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic detect_enable_in,
  input wire logic user_mode_in,
  input wire logic cfg_wr_en_in,
  input wire logic [6:0] cfg_wr_addr_in,
  input wire crc_check_pkg::word_t cfg_wr_data_in,
  input wire logic [9:0] tap_instr_in,
  input wire logic tap_capture_in,
  input wire logic tap_shift_in,
  input wire logic tap_update_in,
  input wire logic tdi_in,
  input wire logic user_capture_in,
  input wire logic user_shift_in,
  input wire logic user_update_en_in,
  input wire logic tap_update_en_in,
  output logic crc_error_out,
  output logic crc_error_oe_n_out,
  output logic tdo_out,
  output logic user_shift_out,
  output logic [3:0] error_type_out
);
  import crc_check_pkg::*;

  localparam logic [6:0] LAST_WORD = 7'(`FRAME_WORDS - 1);
  localparam logic [2:0] LAST_FRAME = 3'(`FRAME_COUNT - 1);
  localparam logic [5:0] UPD_LAST = 6'(`REPORT_UPDATE_CYCLES - 1);
  localparam logic [5:0] UPD_PRE = 6'(`REPORT_UPDATE_CYCLES - 2);
  localparam logic [5:0] LOW_LAST = 6'(`FLAG_LOW_CYCLES - 1);

  function automatic word_t crc_step(input word_t crc, input word_t data);
    word_t c;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      c = (c[31] ^ data[i]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // A CRC syndrome cannot locate bits, so a per-frame XOR word gives the bit pattern.
  function automatic logic [3:0] classify(input word_t syn, input word_t diff);
    logic [3:0] t;
    t = `ERR_OTHER;
    if (syn == 32'h0) begin
      t = `ERR_NONE;
    end else if ($countones(diff) == 1) begin
      t = `ERR_SINGLE;
    end else if ($countones(diff) == 2 && ((diff & (diff << 1)) != 32'h0)) begin
      t = `ERR_DOUBLE;
    end
    return t;
  endfunction

  check_state_t state_reg, state_next;
  logic [2:0] frame_reg;
  logic [3:0] word_reg;
  logic [5:0] cnt_reg;
  word_t crc_reg;
  word_t golden_reg [0:`FRAME_COUNT-1];
  logic [`FI_WIDTH-1:0] tap_fi_reg;
  logic [`FI_WIDTH-1:0] fi_reg;
  word_t xor_reg;
  word_t golden_xor_reg [0:`FRAME_COUNT-1];
  report_t error_message_reg;
  report_t tap_upd_reg, tap_sh_reg;
  report_t user_upd_reg, user_sh_reg;
  logic report_valid_reg;
  logic primed_reg;
  logic last_word_reg;
  word_t rd_data;
  logic [6:0] rd_addr;

  frame_mem u_mem (
    .core_clk_in(core_clk_in),
    .rd_addr_in(rd_addr),
    .wr_en_in(cfg_wr_en_in),
    .wr_addr_in(cfg_wr_addr_in),
    .wr_data_in(cfg_wr_data_in),
    .rd_data_out(rd_data)
  );

  // Injection masks only the word that holds the chosen byte of the first frame.
  wire logic [3:0] fi_type = fi_reg[`FI_TYPE_MSB:`FI_TYPE_LSB];
  wire logic [9:0] fi_loc = fi_reg[`FI_LOC_MSB:`FI_LOC_LSB];
  wire word_t fi_mask = fi_reg[`FI_BYTE_VAL_MSB:`FI_BYTE_VAL_LSB];
  wire logic fi_active = (fi_type == `ERR_SINGLE) || (fi_type == `ERR_DOUBLE);
  wire logic [3:0] data_word = word_reg - 4'h1;
  wire logic fi_hit = fi_active && (frame_reg == 3'h0)
    && (fi_loc[9:2] == {4'h0, data_word});
  wire word_t data_in = fi_hit ? (rd_data ^ fi_mask) : rd_data;
  wire word_t crc_new = crc_step(crc_reg, data_in);
  wire word_t xor_new = xor_reg ^ data_in;
  wire logic active = (state_reg != ST_IDLE);
  wire logic calc_word = active && ((word_reg != 4'h0) || last_word_reg);
  wire word_t syndrome = crc_new ^ golden_reg[frame_reg];
  wire word_t xor_diff = xor_new ^ golden_xor_reg[frame_reg];
  wire logic frame_done = active && last_word_reg;
  wire logic tap_fi_sel = (tap_instr_in == `FAULT_INJECT_CODE);
  wire logic tap_rep_sel = (tap_instr_in == `REPORT_SHIFT_CODE);
  wire logic [2:0] frame_inc = (frame_reg == LAST_FRAME) ? 3'h0 : frame_reg + 3'h1;
  // Word 0 of the next frame is fetched while the last word is still being folded in.
  assign rd_addr = {(last_word_reg ? frame_inc : frame_reg), word_reg};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (detect_enable_in && user_mode_in) state_next = ST_CALC;
      ST_CALC: if (frame_done) begin
        state_next = (primed_reg && syndrome != 32'h0) ? ST_UPDATE : ST_CALC;
      end
      ST_UPDATE: if (cnt_reg == UPD_LAST) state_next = ST_FLAG;
      ST_FLAG: if (frame_done) state_next = ST_LOW;
      ST_LOW: if (cnt_reg == LOW_LAST) state_next = ST_CALC;
    endcase
  end

  // The first pass records each frame's signature so later passes detect changes.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      frame_reg <= 3'h0;
      word_reg <= 4'h0;
      cnt_reg <= 6'h0;
      crc_reg <= `CRC_INIT;
      primed_reg <= 1'b0;
      last_word_reg <= 1'b0;
      xor_reg <= 32'h0;
      error_message_reg <= '0;
      report_valid_reg <= 1'b0;
      for (int i = 0; i < `FRAME_COUNT; i++) golden_reg[i] <= 32'h0;
      for (int i = 0; i < `FRAME_COUNT; i++) golden_xor_reg[i] <= 32'h0;
    end else begin
      state_reg <= state_next;
      report_valid_reg <= 1'b0;
      cnt_reg <= (state_next != state_reg) ? 6'h0 : cnt_reg + 6'h1;
      // Frames keep streaming in every active state, so a found error never stalls.
      if (state_reg != ST_IDLE) begin
        word_reg <= (word_reg == LAST_WORD[3:0]) ? 4'h0 : word_reg + 4'h1;
        last_word_reg <= (word_reg == LAST_WORD[3:0]);
        if (calc_word) crc_reg <= crc_new;
        if (calc_word) xor_reg <= xor_new;
        if (frame_done) begin
          crc_reg <= `CRC_INIT;
          xor_reg <= 32'h0;
          frame_reg <= frame_inc;
          if (!primed_reg) golden_reg[frame_reg] <= crc_new;
          if (!primed_reg) golden_xor_reg[frame_reg] <= xor_new;
          if (frame_reg == LAST_FRAME) primed_reg <= 1'b1;
          if (state_reg == ST_CALC && primed_reg && syndrome != 32'h0) begin
            error_message_reg <= {classify(syndrome, xor_diff), 28'h0, frame_reg, syndrome};
          end
        end
      end
      // Valid one cycle early so the update registers hold the report as the flag rises.
      if (state_reg == ST_UPDATE && cnt_reg == UPD_PRE) report_valid_reg <= 1'b1;
    end
  end

  // Update registers hold their value unless their enable is asserted.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tap_upd_reg <= '0;
      user_upd_reg <= '0;
    end else begin
      if (report_valid_reg && tap_update_en_in) tap_upd_reg <= error_message_reg;
      if (report_valid_reg && user_update_en_in) user_upd_reg <= error_message_reg;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tap_sh_reg <= '0;
      user_sh_reg <= '0;
      tap_fi_reg <= '0;
      fi_reg <= '0;
    end else begin
      if (tap_rep_sel && tap_capture_in) tap_sh_reg <= tap_upd_reg;
      else if (tap_rep_sel && tap_shift_in) tap_sh_reg <= {tdi_in, tap_sh_reg[66:1]};
      if (tap_fi_sel && tap_shift_in) tap_fi_reg <= {tdi_in, tap_fi_reg[45:1]};
      if (tap_fi_sel && tap_update_in) fi_reg <= tap_fi_reg;
      if (user_capture_in) user_sh_reg <= user_upd_reg;
      else if (user_shift_in) user_sh_reg <= {1'b0, user_sh_reg[66:1]};
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc_error_out <= 1'b0;
      crc_error_oe_n_out <= 1'b1;
      tdo_out <= 1'b0;
      user_shift_out <= 1'b0;
      error_type_out <= `ERR_NONE;
    end else begin
      crc_error_out <= (state_next == ST_FLAG);
      crc_error_oe_n_out <= (state_next == ST_IDLE);
      tdo_out <= tap_fi_sel ? tap_fi_reg[0] : tap_sh_reg[0];
      user_shift_out <= user_sh_reg[0];
      error_type_out <= error_message_reg[`REPORT_TYPE_MSB:`REPORT_TYPE_LSB];
    end
  end
endmodule

// File: config_crc_checker_asserts.sv
// Concurrent checks on the configuration checker ports.
module config_crc_checker_asserts (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic detect_enable_in,
  input wire logic user_mode_in,
  input wire logic user_capture_in,
  input wire logic user_shift_in,
  input wire logic crc_error_out,
  input wire logic crc_error_oe_n_out,
  input wire logic user_shift_out,
  input wire logic [3:0] error_type_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] low_cnt;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Saturates so a long quiet spell cannot wrap and fake a short gap.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) low_cnt <= 6'h0;
    else if (crc_error_out) low_cnt <= 6'h0;
    else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h1;
  end
  property p_rst_vals;
    $rose(rst_n_in) |-> !crc_error_out && crc_error_oe_n_out;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("flag not idle after reset");
  property p_gap;
    $rose(crc_error_out) |-> low_cnt >= 6'h20;
  endproperty
  a_gap: assert property (p_gap) else $error("flag low gap too short");
  property p_enable;
    $rose(crc_error_out) |-> detect_enable_in && user_mode_in;
  endproperty
  a_enable: assert property (p_enable) else $error("flag without checking");
  property p_drop;
    $rose(crc_error_out) |=> ##[0:200] !crc_error_out;
  endproperty
  a_drop: assert property (p_drop) else $error("flag stuck high");
  property p_code;
    $rose(crc_error_out) |-> error_type_out inside {4'h1, 4'h2, 4'hf};
  endproperty
  a_code: assert property (p_code) else $error("bad type code");
  property p_ready;
    $rose(crc_error_out) |-> $stable(error_type_out);
  endproperty
  a_ready: assert property (p_ready) else $error("report late");
  property p_oe;
    crc_error_out |-> !crc_error_oe_n_out;
  endproperty
  a_oe: assert property (p_oe) else $error("flag pin undriven");
  // The serial output lags the shift register by one cycle, so the check looks two cycles past the first idle cycle.
  property p_user_hold;
    !user_shift_in && !user_capture_in ##1 !user_shift_in && !user_capture_in
      |=> $stable(user_shift_out);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("shift out moved");
endmodule
bind config_crc_checker config_crc_checker_asserts u_asserts (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .detect_enable_in(detect_enable_in),
  .user_mode_in(user_mode_in), .user_capture_in(user_capture_in),
  .user_shift_in(user_shift_in), .crc_error_out(crc_error_out),
  .crc_error_oe_n_out(crc_error_oe_n_out), .user_shift_out(user_shift_out),
  .error_type_out(error_type_out)
);

// File: tap_model.sv
// Test-port controller model that loads the fault injection register.
module tap_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [45:0] val_in,
  output logic [9:0] instr_out,
  output logic shift_out,
  output logic update_out,
  output logic tdi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    instr_out = 10'h017;
    shift_out = 1'h0;
    update_out = 1'h0;
    tdi_out = 1'h0;
    forever begin
      @(posedge clk_in iff go_in);
      #1 instr_out = 10'h015;
      for (int i = 0; i < 46; i++) begin
        shift_out = 1'h1;
        tdi_out = val_in[i];
        @(posedge clk_in);
        #1;
      end
      shift_out = 1'h0;
      tdi_out = ~tdi_out;
      update_out = 1'h1;
      @(posedge clk_in);
      #1 update_out = 1'h0;
      instr_out = 10'h017;
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for the configuration checker.
`include "crc_check_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import crc_check_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, en = 1'h0, um = 1'h0, wr_en = 1'h0, go = 1'h0;
  logic ucap = 1'h0, ushift = 1'h0, crc_err, oe_n, us_out, tshift, tupd, tdi;
  logic [6:0] wr_addr = 7'h0;
  word_t wr_data = 32'h0;
  logic [9:0] instr;
  logic [3:0] etype;
  logic [45:0] fi_val = 46'h0;
  report_t rep;
  int errors = 0;
  int n_tests = 0;
  int t, k;
  always #20 clk = ~clk;
  config_crc_checker u_config_crc_checker (
    .core_clk_in(clk), .rst_n_in(rst_n), .detect_enable_in(en), .user_mode_in(um),
    .cfg_wr_en_in(wr_en), .cfg_wr_addr_in(wr_addr), .cfg_wr_data_in(wr_data),
    .tap_instr_in(instr), .tap_capture_in(1'h0), .tap_shift_in(tshift),
    .tap_update_in(tupd), .tdi_in(tdi), .user_capture_in(ucap), .user_shift_in(ushift),
    .user_update_en_in(1'h1), .tap_update_en_in(1'h1), .crc_error_out(crc_err),
    .crc_error_oe_n_out(oe_n), .tdo_out(), .user_shift_out(us_out), .error_type_out(etype)
  );
  tap_model u_tap_model (.clk_in(clk), .go_in(go), .val_in(fi_val), .instr_out(instr),
    .shift_out(tshift), .update_out(tupd), .tdi_out(tdi));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task boot;
    rst_n = 1'h0;
    en = 1'h0;
    um = 1'h0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    chk(32'(oe_n), 32'h1);
    for (k = 0; k < 128; k++) begin
      wr_en = 1'h1;
      wr_addr = k[6:0];
      wr_data = 32'h9e3779b1 * k;
      @(posedge clk);
      #1;
    end
    wr_en = 1'h0;
    en = 1'h1;
    um = 1'h1;
    repeat (400) @(posedge clk);
    #1 chk(32'(crc_err), 32'h0);
    chk(32'(oe_n), 32'h0);
  endtask
  // Capture is taken at once so the report cannot be replaced mid-read.
  task read_rep;
    ucap = 1'h1;
    @(posedge clk);
    #1 ucap = 1'h0;
    ushift = 1'h1;
    for (k = 0; k < 67; k++) begin
      @(posedge clk);
      #1 rep[k] = us_out;
    end
    ushift = 1'h0;
  endtask
  initial begin
    for (t = 0; t < 3; t++) begin
      boot;
      fi_val = {t[3:0], 10'h008, (t == 2) ? 32'h3 : 32'h1};
      go = 1'h1;
      @(posedge clk);
      #1 go = 1'h0;
      k = 0;
      while (crc_err !== 1'h1 && k < 1000) begin
        @(posedge clk);
        #1 k++;
      end
      if (t == 0) chk(32'(crc_err), 32'h0);
      else begin
        chk(32'(crc_err), 32'h1);
        chk(32'(etype), (t == 1) ? `ERR_SINGLE : `ERR_DOUBLE);
        read_rep;
        chk(32'(rep[66:63]), (t == 1) ? `ERR_SINGLE : `ERR_DOUBLE);
        chk(32'(rep[34:32]), 32'h0);
        chk(32'(rep[31:0] != 32'h0), 32'h1);
        chk(32'(crc_err), 32'h0);
      end
    end
    wrap_up;
  end
  initial begin
    #800000;
    errors++;
    wrap_up;
  end
endmodule
